/* File: design/efr_pkg.sv */
// constants and types shared by the event link framer
package efr_pkg;
	// event words
	localparam logic [15:0] EFR_START_MARK = 16'hF000;
	localparam logic [15:0] EFR_MARK_IND = 16'hFFFF;
	localparam logic [15:0] EFR_NO_SRC = 16'hFFFF;
	localparam logic [15:0] EFR_ZERO = 16'h0000;
	localparam logic [1:0] EFR_MT_FILL = 2'h1;
	localparam logic [1:0] EFR_MT_GREY = 2'h2;
	localparam logic [1:0] EFR_MT_CAL = 2'h3;
	localparam logic [5:0] EFR_HDR_WORDS = 6'h03;
	localparam logic [5:0] EFR_LEN_NORM = 6'h06;
	localparam logic [5:0] EFR_LEN_CAL = 6'h25;
	localparam logic [5:0] EFR_LEN_DIAG = 6'h2B;
	// request envelope and indicators
	localparam logic [15:0] EFR_ENV_START = 16'hDDDD;
	localparam logic [15:0] EFR_ENV_TERM1 = 16'h3333;
	localparam logic [15:0] EFR_ENV_TERM2 = 16'h6666;
	localparam logic [15:0] EFR_ID_STATE = 16'h1234;
	localparam logic [15:0] EFR_ID_PINT = 16'h8642;
	localparam logic [15:0] EFR_ID_PFLT = 16'h8765;
	localparam logic [15:0] EFR_ID_MEMUP = 16'hABCD;
	localparam logic [15:0] EFR_ID_HW = 16'hAAAA;
	localparam logic [15:0] EFR_ID_DUMP = 16'hCADB;
	localparam logic [15:0] EFR_ID_MCRC = 16'hFEDC;
	localparam logic [15:0] EFR_ID_STAT = 16'h2323;
	localparam logic [15:0] EFR_ID_HKREQ = 16'h4711;
	localparam logic [15:0] EFR_ID_ACK = 16'hF00F;
	localparam logic [8:0] EFR_RQ_STATE_LEN = 9'h004;
	localparam logic [8:0] EFR_RQ_PAR_LEN = 9'h005;
	localparam logic [8:0] EFR_RQ_HW_LEN = 9'h004;
	localparam logic [8:0] EFR_RQ_MEM_OVH = 9'h004;
	localparam logic [8:0] EFR_RQ_MEM_MAXN = 9'h100;
	localparam logic [8:0] EFR_RQ_MAX_LEN = 9'h104;
	// state numbers
	localparam logic [5:0] EFR_ST_SAFE = 6'h01;
	localparam logic [5:0] EFR_ST_PATCH = 6'h02;
	localparam logic [5:0] EFR_ST_SETUP = 6'h05;
	localparam logic [5:0] EFR_ST_TAKE = 6'h0A;
	localparam logic [5:0] EFR_ST_CAL = 6'h14;
	localparam logic [5:0] EFR_ST_DIAG = 6'h28;
	// acknowledge status
	localparam logic [15:0] EFR_AK_OK = 16'h0000;
	localparam logic [15:0] EFR_AK_CRC = 16'h0001;
	localparam logic [15:0] EFR_AK_UNREC = 16'h0002;
	localparam logic [15:0] EFR_AK_INVAL = 16'h0003;
	localparam logic [15:0] EFR_AK_BADNUM = 16'h0004;
	localparam logic [15:0] EFR_AK_RANGE = 16'h0005;
	// crc
	localparam logic [15:0] EFR_CRC_POLY = 16'h1021;
	localparam logic [15:0] EFR_CRC_INIT = 16'hFFFF;
	// timing and sizes
	localparam int EFR_CLK_MHZ = 250;
	localparam int EFR_RSP_MIN_US = 100;
	localparam int EFR_RSP_MIN_CYC = EFR_RSP_MIN_US * EFR_CLK_MHZ;
	localparam int EFR_TICK_DIV = 250;
	localparam int EFR_FIFO_DEPTH = 8192;
	// register offsets, fields, reset values
	localparam logic [7:0] EFR_REG_CTRL = 8'h00;
	localparam logic [7:0] EFR_REG_MARK = 8'h04;
	localparam logic [7:0] EFR_REG_HKCYC = 8'h08;
	localparam logic [7:0] EFR_REG_STATUS = 8'h0C;
	localparam logic [7:0] EFR_REG_STPAR = 8'h10;
	localparam int EFR_CTRL_EN_BIT = 0;
	localparam int EFR_MARK_TYPE_LSB = 16;
	localparam int EFR_STAT_CNT_LSB = 16;
	localparam logic EFR_CTRL_EN_RST = 1'b0;
	localparam logic [31:0] EFR_UNMAPPED = 32'h00000000;
	typedef enum logic [1:0] {EFR_FMT_NONE, EFR_FMT_NORM, EFR_FMT_CAL, EFR_FMT_DIAG} efr_fmt_t;
	typedef enum logic [1:0] {EFR_RX_IDLE = 2'b00, EFR_RX_START2 = 2'b01, EFR_RX_BODY = 2'b11,
		EFR_RX_TERM = 2'b10} efr_rx_t;
	typedef enum logic [1:0] {EFR_RS_IDLE = 2'b00, EFR_RS_WAIT = 2'b01, EFR_RS_SEND = 2'b11} efr_rs_t;
endpackage

/* File: design/efr_crc16.sv */
// word-wide crc accumulator for the command link
`timescale 1ns/1ns
module efr_crc16
	import efr_pkg::*;
#(
	parameter logic [15:0] POLY = EFR_CRC_POLY,
	parameter logic [15:0] INIT = EFR_CRC_INIT
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// control and data
	input wire logic clear_i,
	input wire logic en_i,
	input wire logic [15:0] word_i,
	output logic [15:0] crc_o
);
	logic [15:0] nxt_crc;

	always_comb begin
		nxt_crc = crc_o;
		for (int b = 15; b >= 0; b--) begin
			nxt_crc = {nxt_crc[14:0], 1'b0} ^ ((nxt_crc[15] ^ word_i[b]) ? POLY : 16'h0000);
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			crc_o <= EFR_CRC_INIT;
		end else if (clear_i) begin
			crc_o <= INIT;
		end else if (en_i) begin
			crc_o <= nxt_crc;
		end
	end
endmodule

/* File: design/efr_framer.sv */
// event link framer: output fifo framing, command receiver and acknowledge
`timescale 1ns/1ns
// Operation
// - fast link sends fifo words outward only.
// - half-full: a 4096-word block is ready; events may straddle.
// - markers match the word count of the running format.
// - normal event: F000, count, timer, anode, back, cathode.
// - normal marker: FFFF, type 1 or 2, then 0 or filter.
// - leaving data taking, fillers flush out real events.
// - calibration event: 37 words of raw signals.
// - calibration marker: type 1 or 3, amplitude, triggers, zeros.
// - diagnostic event: 43 words, outputs plus raw inputs.
// - diagnostic source word: source 0 to 3, or -1.
// - diagnostic status zero accepts; field validity follows status.
// - diagnostic marker: FFFF, type 1, words 6 to 43 zero.
// - half duplex: no request taken while answering.
// - data taking accepts only a change to setup; queries still raise qry_o in any state.
// - parameter and hardware commands only in setup.
// - uplink only in patch state, entered only from safe.
// - requests framed by DDDD DDDD, 3333 6666; answers bare.
// - state change: 1234, target, parameter, crc.
// - states: safe 1, patch 2, setup 5, take 10, cal 20, diag 40.
// - each state change request is acknowledged.
// - parameter change: five words, 8642 or 8765 first.
// - acknowledge: F00F, status code, crc.
// - answers start at least 100 us after the request.
module efr_framer
	import efr_pkg::*;
#(
	parameter int RSP_DLY_CYC = EFR_RSP_MIN_CYC,
	parameter int FIFO_DEPTH = EFR_FIFO_DEPTH,
	parameter int TICK_DIV = EFR_TICK_DIV
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// event source
	input wire logic evt_valid_i,
	input wire logic [15:0] evt_word_i,
	input wire logic evt_cal_hit_i,
	input wire logic [1:0] evt_cal_src_i,
	output logic evt_ready_o,
	// fast event link
	input wire logic hs_rd_i,
	output logic [15:0] hs_data_o,
	output logic hs_half_full_o,
	// command link
	input wire logic ls_rx_valid_i,
	input wire logic [15:0] ls_rx_word_i,
	output logic ls_tx_valid_o,
	output logic [15:0] ls_tx_word_o,
	// command results
	output logic cmd_exec_o,
	output logic [15:0] cmd_id_o,
	output logic [15:0] cmd_arg1_o,
	output logic [15:0] cmd_arg2_o,
	output logic [15:0] cmd_arg3_o,
	output logic qry_o,
	output logic [5:0] op_state_o
);
	localparam int AW = $clog2(FIFO_DEPTH);
	localparam logic [AW:0] HALF = (AW+1)'(FIFO_DEPTH / 2);
	localparam logic [AW:0] ROOM = (AW+1)'(FIFO_DEPTH - 4);
	localparam logic [23:0] DLY_LOAD = 24'(RSP_DLY_CYC - 1);
	localparam logic [15:0] TICK_LAST = 16'(TICK_DIV - 1);

	function automatic efr_fmt_t fmt_of(input logic [5:0] st);
		case (st)
			EFR_ST_TAKE: fmt_of = EFR_FMT_NORM;
			EFR_ST_CAL: fmt_of = EFR_FMT_CAL;
			EFR_ST_DIAG: fmt_of = EFR_FMT_DIAG;
			default: fmt_of = EFR_FMT_NONE;
		endcase
	endfunction

	function automatic logic [5:0] len_of(input efr_fmt_t f);
		len_of = (f == EFR_FMT_CAL) ? EFR_LEN_CAL : ((f == EFR_FMT_DIAG) ? EFR_LEN_DIAG : EFR_LEN_NORM);
	endfunction

	// payload word positions
	function automatic logic is_pay(input efr_fmt_t f, input logic mk, input logic [5:0] idx);
		is_pay = !mk && idx >= EFR_HDR_WORDS && !(f == EFR_FMT_DIAG && idx == EFR_LEN_DIAG - 6'h01);
	endfunction

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		for (int i = 0; i < 4; i++) begin
			wmerge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	// registers and state
	logic en_ff;
	logic [15:0] mk_par_ff;
	logic [1:0] mk_typ_ff;
	logic mk_pend_ff;
	logic [15:0] hk_ff;
	logic [15:0] timer_ff;
	logic [15:0] tick_ff;
	logic [5:0] op_st_ff;
	logic [15:0] st_par_ff;
	logic [15:0] mem [FIFO_DEPTH];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [AW:0] cnt_ff;
	logic busy_ff;
	logic mk_ff;
	logic [1:0] typ_ff;
	logic [15:0] par_ff;
	efr_fmt_t fmt_ff;
	logic [5:0] idx_ff;
	logic flush_ff;
	efr_fmt_t flush_fmt_ff;
	efr_fmt_t st_fmt_ff;
	logic [AW:0] pend_ff;
	efr_rx_t rx_st_ff;
	logic [8:0] bcnt_ff;
	logic [15:0] buf_ff [4];
	logic [15:0] last_ff;
	logic [15:0] prev_crc_ff;
	logic done_ff;
	logic ack_go_ff;
	logic [15:0] ack_st_ff;
	efr_rs_t rs_st_ff;
	logic [23:0] dly_ff;
	logic [1:0] tstep_ff;
	logic [1:0] sidx_ff;
	logic [15:0] rx_crc;
	logic [15:0] tx_crc;

	// wishbone slave
	logic wb_req;
	logic wb_wr;
	logic [31:0] mark_rd, mark_wr, hk_wr;
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	assign mark_rd = {14'h0000, mk_typ_ff, mk_par_ff};
	assign mark_wr = wmerge(mark_rd, wb_dat_i, wb_sel_i);
	assign hk_wr = wmerge({16'h0000, hk_ff}, wb_dat_i, wb_sel_i);

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= EFR_UNMAPPED;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					EFR_REG_CTRL: wb_dat_o <= {31'h00000000, en_ff};
					EFR_REG_MARK: wb_dat_o <= mark_rd;
					EFR_REG_HKCYC: wb_dat_o <= {16'h0000, hk_ff};
					EFR_REG_STATUS: wb_dat_o <= {(16-(AW+1))'(0), cnt_ff, 5'h00, hs_half_full_o, flush_ff,
						mk_pend_ff, 2'h0, op_st_ff};
					EFR_REG_STPAR: wb_dat_o <= {16'h0000, st_par_ff};
					default: wb_dat_o <= EFR_UNMAPPED;
				endcase
			end
		end
	end

	logic mk_take;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_ff <= EFR_CTRL_EN_RST;
			mk_par_ff <= EFR_ZERO;
			mk_typ_ff <= EFR_MT_FILL;
			hk_ff <= EFR_ZERO;
		end else if (wb_wr) begin
			if (wb_adr_i == EFR_REG_CTRL && wb_sel_i[0]) begin
				en_ff <= wb_dat_i[EFR_CTRL_EN_BIT];
			end
			if (wb_adr_i == EFR_REG_MARK) begin
				{mk_typ_ff, mk_par_ff} <= mark_wr[EFR_MARK_TYPE_LSB+1:0];
			end
			if (wb_adr_i == EFR_REG_HKCYC) begin
				hk_ff <= hk_wr[15:0];
			end
		end
	end

	// marker request: write wins over take
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mk_pend_ff <= 1'b0;
		end else if (wb_wr && wb_adr_i == EFR_REG_MARK) begin
			mk_pend_ff <= 1'b1;
		end else if (mk_take) begin
			mk_pend_ff <= 1'b0;
		end
	end

	// timer with divided tick
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_ff <= 16'h0000;
			timer_ff <= 16'h0000;
		end else if (tick_ff == TICK_LAST) begin
			tick_ff <= 16'h0000;
			timer_ff <= timer_ff + 16'h0001;
		end else begin
			tick_ff <= tick_ff + 16'h0001;
		end
	end

	// event framing
	efr_fmt_t fmt_run;
	efr_fmt_t c_fmt;
	logic room, start_mk, start_ev, c_mk, pay, wr_en, last, rd_ok;
	logic [1:0] c_typ;
	logic [15:0] c_par;
	logic [5:0] c_idx;
	logic [15:0] word;
	logic nxt_busy;
	logic [5:0] nxt_idx;

	always_comb begin
		fmt_run = flush_ff ? flush_fmt_ff : (en_ff ? fmt_of(op_st_ff) : EFR_FMT_NONE);
		room = cnt_ff <= ROOM;
		start_mk = 1'b0;
		start_ev = 1'b0;
		if (!busy_ff && room && fmt_run != EFR_FMT_NONE) begin
			if (flush_ff) begin
				start_mk = (pend_ff != '0) && (cnt_ff < HALF);
			end else if (mk_pend_ff) begin
				start_mk = 1'b1;
			end else begin
				start_ev = evt_valid_i;
			end
		end
		c_fmt = busy_ff ? fmt_ff : fmt_run;
		c_mk = busy_ff ? mk_ff : start_mk;
		c_typ = busy_ff ? typ_ff : EFR_MT_FILL;
		if (!busy_ff && !flush_ff && ((mk_typ_ff == EFR_MT_GREY && fmt_run == EFR_FMT_NORM) ||
			(mk_typ_ff == EFR_MT_CAL && fmt_run == EFR_FMT_CAL))) begin
			c_typ = mk_typ_ff;
		end
		c_par = busy_ff ? par_ff : mk_par_ff;
		c_idx = busy_ff ? idx_ff : 6'h00;
		pay = is_pay(c_fmt, c_mk, c_idx);
		wr_en = start_mk | start_ev | (busy_ff && (pay ? (evt_ready_o & evt_valid_i) : room));
		last = c_idx == len_of(c_fmt) - 6'h01;
		if (c_idx == 6'h00) begin
			word = EFR_START_MARK;
		end else if (c_idx == 6'h01) begin
			word = hk_ff;
		end else if (c_idx == 6'h02) begin
			word = timer_ff;
		end else if (c_mk) begin
			case (c_idx)
				6'h03: word = EFR_MARK_IND;
				6'h04: word = {14'h0000, c_typ};
				6'h05: word = (c_typ == EFR_MT_FILL) ? EFR_ZERO : c_par;
				6'h06: word = (c_typ == EFR_MT_CAL) ? st_par_ff : EFR_ZERO;
				default: word = EFR_ZERO;
			endcase
		end else if (pay) begin
			word = evt_word_i;
		end else begin
			word = evt_cal_hit_i ? {14'h0000, evt_cal_src_i} : EFR_NO_SRC;
		end
		nxt_busy = wr_en ? !last : busy_ff;
		nxt_idx = (wr_en && !last) ? c_idx + 6'h01 : ((wr_en || !busy_ff) ? 6'h00 : c_idx);
	end

	assign mk_take = start_mk && !flush_ff;
	assign rd_ok = hs_rd_i && cnt_ff != '0;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_ff <= 1'b0;
			mk_ff <= 1'b0;
			typ_ff <= EFR_MT_FILL;
			par_ff <= EFR_ZERO;
			fmt_ff <= EFR_FMT_NONE;
			idx_ff <= 6'h00;
			evt_ready_o <= 1'b0;
		end else begin
			busy_ff <= nxt_busy;
			idx_ff <= nxt_idx;
			if (!busy_ff) begin
				mk_ff <= start_mk;
				typ_ff <= c_typ;
				par_ff <= c_par;
				fmt_ff <= fmt_run;
			end
			evt_ready_o <= nxt_busy && is_pay(busy_ff ? fmt_ff : fmt_run, busy_ff ? mk_ff : start_mk, nxt_idx);
		end
	end

	// filler flush on leaving an event state
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_fmt_ff <= EFR_FMT_NONE;
			flush_ff <= 1'b0;
			flush_fmt_ff <= EFR_FMT_NONE;
			pend_ff <= '0;
		end else begin
			st_fmt_ff <= fmt_of(op_st_ff);
			if (en_ff && st_fmt_ff != EFR_FMT_NONE && fmt_of(op_st_ff) != st_fmt_ff) begin
				flush_ff <= 1'b1;
				flush_fmt_ff <= st_fmt_ff;
				pend_ff <= cnt_ff;
			end else begin
				if (rd_ok && pend_ff != '0) begin
					pend_ff <= pend_ff - (AW+1)'(1);
				end
				if (flush_ff && pend_ff == '0 && !busy_ff) begin
					flush_ff <= 1'b0;
				end
			end
		end
	end

	// output fifo toward the fast link
	always_ff @(posedge clock_i) begin
		if (wr_en) begin
			mem[wp_ff] <= word;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
			hs_data_o <= EFR_ZERO;
			hs_half_full_o <= 1'b0;
		end else begin
			if (wr_en) begin
				wp_ff <= wp_ff + AW'(1);
			end
			if (rd_ok) begin
				rp_ff <= rp_ff + AW'(1);
				hs_data_o <= mem[rp_ff];
			end
			cnt_ff <= cnt_ff + (AW+1)'(wr_en) - (AW+1)'(rd_ok);
			hs_half_full_o <= (cnt_ff + (AW+1)'(wr_en) - (AW+1)'(rd_ok)) >= HALF;
		end
	end

	// command receiver
	logic rx_take;
	logic rx_store;
	assign rx_take = ls_rx_valid_i && rs_st_ff == EFR_RS_IDLE && !ack_go_ff && !done_ff;
	assign rx_store = rx_take && rx_st_ff == EFR_RX_BODY && ls_rx_word_i != EFR_ENV_TERM1;

	efr_crc16 u_rx_crc (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.clear_i(rx_take && rx_st_ff == EFR_RX_START2),
		.en_i(rx_store),
		.word_i(ls_rx_word_i),
		.crc_o(rx_crc)
	);

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_st_ff <= EFR_RX_IDLE;
			bcnt_ff <= 9'h000;
			last_ff <= EFR_ZERO;
			prev_crc_ff <= EFR_ZERO;
			done_ff <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				buf_ff[i] <= EFR_ZERO;
			end
		end else begin
			done_ff <= 1'b0;
			if (rx_take) begin
				unique case (rx_st_ff)
					EFR_RX_IDLE: begin
						if (ls_rx_word_i == EFR_ENV_START) rx_st_ff <= EFR_RX_START2;
					end
					EFR_RX_START2: begin
						rx_st_ff <= (ls_rx_word_i == EFR_ENV_START) ? EFR_RX_BODY : EFR_RX_IDLE;
						bcnt_ff <= 9'h000;
					end
					EFR_RX_BODY: begin
						if (ls_rx_word_i == EFR_ENV_TERM1) begin
							rx_st_ff <= EFR_RX_TERM;
						end else begin
							if (bcnt_ff < 9'h004) buf_ff[bcnt_ff[1:0]] <= ls_rx_word_i;
							if (bcnt_ff != 9'h1FF) bcnt_ff <= bcnt_ff + 9'h001;
							prev_crc_ff <= rx_crc;
							last_ff <= ls_rx_word_i;
						end
					end
					EFR_RX_TERM: begin
						done_ff <= ls_rx_word_i == EFR_ENV_TERM2;
						rx_st_ff <= (ls_rx_word_i == EFR_ENV_START) ? EFR_RX_START2 : EFR_RX_IDLE;
					end
				endcase
			end
		end
	end

	// request decode and state control
	logic crc_ok;
	logic tgt_ok;
	logic [5:0] tgt;
	assign crc_ok = last_ff == prev_crc_ff;
	assign tgt = buf_ff[1][5:0];
	assign tgt_ok = buf_ff[1][15:6] == 10'h000 && (tgt == EFR_ST_SAFE || tgt == EFR_ST_PATCH ||
		tgt == EFR_ST_SETUP || tgt == EFR_ST_TAKE || tgt == EFR_ST_CAL || tgt == EFR_ST_DIAG);

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			op_st_ff <= EFR_ST_SAFE;
			st_par_ff <= EFR_ZERO;
			ack_go_ff <= 1'b0;
			ack_st_ff <= EFR_AK_OK;
			cmd_exec_o <= 1'b0;
			qry_o <= 1'b0;
			cmd_id_o <= EFR_ZERO;
			cmd_arg1_o <= EFR_ZERO;
			cmd_arg2_o <= EFR_ZERO;
			cmd_arg3_o <= EFR_ZERO;
		end else begin
			ack_go_ff <= 1'b0;
			cmd_exec_o <= 1'b0;
			qry_o <= 1'b0;
			if (done_ff) begin
				ack_go_ff <= 1'b1;
				ack_st_ff <= EFR_AK_OK;
				cmd_id_o <= buf_ff[0];
				cmd_arg1_o <= buf_ff[1];
				cmd_arg2_o <= buf_ff[2];
				cmd_arg3_o <= buf_ff[3];
				case (buf_ff[0])
					EFR_ID_STATE: begin
						if (bcnt_ff != EFR_RQ_STATE_LEN) ack_st_ff <= EFR_AK_INVAL;
						else if (!crc_ok) ack_st_ff <= EFR_AK_CRC;
						else if (!tgt_ok) ack_st_ff <= EFR_AK_BADNUM;
						else if (op_st_ff == EFR_ST_TAKE && tgt != EFR_ST_SETUP) ack_st_ff <= EFR_AK_INVAL;
						else if (tgt == EFR_ST_PATCH && op_st_ff != EFR_ST_SAFE) ack_st_ff <= EFR_AK_INVAL;
						else begin
							op_st_ff <= tgt;
							st_par_ff <= buf_ff[2];
							cmd_exec_o <= 1'b1;
						end
					end
					EFR_ID_PINT, EFR_ID_PFLT, EFR_ID_HW: begin
						if (bcnt_ff != ((buf_ff[0] == EFR_ID_HW) ? EFR_RQ_HW_LEN : EFR_RQ_PAR_LEN)) begin
							ack_st_ff <= EFR_AK_INVAL;
						end else if (!crc_ok) ack_st_ff <= EFR_AK_CRC;
						else if (op_st_ff != EFR_ST_SETUP) ack_st_ff <= EFR_AK_INVAL;
						else cmd_exec_o <= 1'b1;
					end
					EFR_ID_MEMUP: begin
						if (buf_ff[2] == EFR_ZERO || buf_ff[2] > {7'h00, EFR_RQ_MEM_MAXN} ||
							bcnt_ff > EFR_RQ_MAX_LEN || bcnt_ff != buf_ff[2][8:0] + EFR_RQ_MEM_OVH) begin
							ack_st_ff <= EFR_AK_RANGE;
						end else if (!crc_ok) ack_st_ff <= EFR_AK_CRC;
						else if (op_st_ff != EFR_ST_PATCH) ack_st_ff <= EFR_AK_INVAL;
						else cmd_exec_o <= 1'b1;
					end
					EFR_ID_DUMP, EFR_ID_MCRC, EFR_ID_STAT, EFR_ID_HKREQ: begin
						ack_go_ff <= 1'b0;
						qry_o <= 1'b1;
					end
					default: ack_st_ff <= EFR_AK_UNREC;
				endcase
			end
		end
	end

	assign op_state_o = op_st_ff;

	// acknowledge sender
	efr_crc16 u_tx_crc (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.clear_i(ack_go_ff),
		.en_i(rs_st_ff == EFR_RS_WAIT && tstep_ff != 2'h2),
		.word_i((tstep_ff == 2'h0) ? EFR_ID_ACK : ack_st_ff),
		.crc_o(tx_crc)
	);

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rs_st_ff <= EFR_RS_IDLE;
			dly_ff <= 24'h000000;
			tstep_ff <= 2'h0;
			sidx_ff <= 2'h0;
			ls_tx_valid_o <= 1'b0;
			ls_tx_word_o <= EFR_ZERO;
		end else begin
			ls_tx_valid_o <= 1'b0;
			unique case (rs_st_ff)
				EFR_RS_IDLE: begin
					if (ack_go_ff) begin
						rs_st_ff <= EFR_RS_WAIT;
						dly_ff <= DLY_LOAD;
						tstep_ff <= 2'h0;
					end
				end
				EFR_RS_WAIT: begin
					if (tstep_ff != 2'h2) tstep_ff <= tstep_ff + 2'h1;
					if (dly_ff == 24'h000000 && tstep_ff == 2'h2) begin
						rs_st_ff <= EFR_RS_SEND;
						sidx_ff <= 2'h0;
					end else if (dly_ff != 24'h000000) begin
						dly_ff <= dly_ff - 24'h000001;
					end
				end
				EFR_RS_SEND: begin
					ls_tx_valid_o <= 1'b1;
					ls_tx_word_o <= (sidx_ff == 2'h0) ? EFR_ID_ACK : ((sidx_ff == 2'h1) ? ack_st_ff : tx_crc);
					sidx_ff <= sidx_ff + 2'h1;
					if (sidx_ff == 2'h2) rs_st_ff <= EFR_RS_IDLE;
				end
			endcase
		end
	end
endmodule

/* File: verification/efr_framer_asserts.sv */
// concurrent checks on the framer ports
`timescale 1ns/1ns
module efr_framer_asserts
	import efr_pkg::*;
#(
	parameter int RSP_DLY_CYC = 20
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// command link
	input wire logic ls_rx_valid_i,
	input wire logic [15:0] ls_rx_word_i,
	input wire logic ls_tx_valid_o,
	input wire logic [15:0] ls_tx_word_o,
	// results
	input wire logic cmd_exec_o,
	input wire logic [5:0] op_state_o
);
	localparam int ACK_MAX = RSP_DLY_CYC + 16;
	int quiet_ff;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// cycles since the last closing word
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) quiet_ff <= 0;
		else if (ls_rx_valid_i && ls_rx_word_i == EFR_ENV_TERM2) quiet_ff <= 0;
		else if (quiet_ff < 100000) quiet_ff <= quiet_ff + 1;
	end
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	a_ack_timely: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	a_answer_frame: assert property ($rose(ls_tx_valid_o) |-> ls_tx_word_o == EFR_ID_ACK
		##1 ls_tx_valid_o && ls_tx_word_o <= 16'h0005 ##1 ls_tx_valid_o ##1 !ls_tx_valid_o) else $error("bad answer");
	a_answer_late: assert property ($rose(ls_tx_valid_o) |-> quiet_ff >= RSP_DLY_CYC) else $error("answer early");
	a_exec_answered: assert property (cmd_exec_o |-> ##[1:ACK_MAX] $rose(ls_tx_valid_o))
		else $error("no answer");
	a_state_code: assert property (op_state_o inside {6'h01, 6'h02, 6'h05, 6'h0A, 6'h14, 6'h28})
		else $error("bad state");
	a_take_leaves: assert property ($past(op_state_o) == EFR_ST_TAKE && op_state_o != EFR_ST_TAKE
		|-> op_state_o == EFR_ST_SETUP) else $error("left take badly");
	a_patch_entry: assert property (op_state_o == EFR_ST_PATCH && $past(op_state_o) != EFR_ST_PATCH
		|-> $past(op_state_o) == EFR_ST_SAFE) else $error("patch not from safe");
endmodule
bind efr_framer efr_framer_asserts #(.RSP_DLY_CYC(RSP_DLY_CYC)) u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ls_rx_valid_i(ls_rx_valid_i),
	.ls_rx_word_i(ls_rx_word_i), .ls_tx_valid_o(ls_tx_valid_o), .ls_tx_word_o(ls_tx_word_o),
	.cmd_exec_o(cmd_exec_o), .op_state_o(op_state_o));

/* File: verification/efr_pu_model.sv */
// processing unit model: requests, answer capture, fifo reads
`timescale 1ns/1ns
module efr_pu_model (
	// clock
	input wire logic clock_i,
	// fast event link
	input wire logic [15:0] hs_data_i,
	output logic hs_rd_o,
	// command link
	input wire logic tx_valid_i,
	input wire logic [15:0] tx_word_i,
	output logic rx_valid_o,
	output logic [15:0] rx_word_o
);
	logic [15:0] ans [0:2];
	int n_ans = 0;
	initial begin
		hs_rd_o = 1'b0;
		rx_valid_o = 1'b0;
		rx_word_o = 16'h0000;
	end
	function automatic logic [15:0] crc(input logic [15:0] c, input logic [15:0] w);
		for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? 16'h1021 : 16'h0000);
		return c;
	endfunction
	always @(posedge clock_i) begin
		if (tx_valid_i) begin
			ans[n_ans % 3] <= tx_word_i;
			n_ans <= n_ans + 1;
		end
	end
	task automatic send(input logic [15:0] w);
		@(posedge clock_i);
		rx_valid_o <= 1'b1;
		rx_word_o <= w;
		@(posedge clock_i);
		rx_valid_o <= 1'b0;
		rx_word_o <= ~w;
	endtask
	// one request, enveloped, crc last
	task automatic req(input logic [15:0] w0, w1, w2, w3, input logic five, bad);
		logic [15:0] c;
		c = crc(crc(crc(16'hFFFF, w0), w1), w2);
		if (five) c = crc(c, w3);
		send(16'hDDDD);
		send(16'hDDDD);
		send(w0);
		send(w1);
		send(w2);
		if (five) send(w3);
		send(c ^ {15'h0000, bad});
		send(16'h3333);
		send(16'h6666);
	endtask
	// one fifo word, only ever read
	task automatic rd(output logic [15:0] w);
		@(posedge clock_i);
		hs_rd_o <= 1'b1;
		@(posedge clock_i);
		hs_rd_o <= 1'b0;
		@(negedge clock_i);
		w = hs_data_i;
	endtask
endmodule

/* File: verification/efr_framer_test.sv */
// testbench for the event link framer
`timescale 1ns/1ns
module efr_framer_test
	import efr_pkg::*;
;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic wb_ack_o, evt_valid_i = 1'b0, evt_cal_hit_i = 1'b0, evt_ready_o;
	logic [1:0] evt_cal_src_i = 2'h0;
	logic [15:0] evt_word_i = 16'h0, hs_data_o, ls_rx_word_i, ls_tx_word_o, w;
	logic hs_rd_i, hs_half_full_o, ls_rx_valid_i, ls_tx_valid_o, cmd_exec_o, qry_o;
	logic [15:0] cmd_id_o, cmd_arg1_o, cmd_arg2_o, cmd_arg3_o;
	logic [5:0] op_state_o;
	int bad_count = 0, checks_done = 0, cyc = 0, n0;
	efr_framer #(.RSP_DLY_CYC(20)) dut (.*);
	efr_pu_model pu (.clock_i(clock_i), .hs_data_i(hs_data_o), .hs_rd_o(hs_rd_i), .tx_valid_i(ls_tx_valid_o),
		.tx_word_i(ls_tx_word_o), .rx_valid_o(ls_rx_valid_i), .rx_word_o(ls_rx_word_i));
	initial forever #2 clock_i = ~clock_i;
	task automatic tally_and_finish;
		$display("checks %0d bad %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			tally_and_finish;
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clock_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic cmd(input logic [15:0] id, t, p, st, input logic [5:0] os, input logic five = 1'b0, bad = 1'b0);
		n0 = pu.n_ans;
		pu.req(id, t, p, 16'h0000, five, bad);
		for (int i = 0; i < 200 && pu.n_ans < n0 + 3; i++) @(posedge clock_i);
		chk("n", pu.n_ans - n0, 3);
		chk("id", pu.ans[0], EFR_ID_ACK);
		chk("st", pu.ans[1], st);
		chk("crc", pu.ans[2], pu.crc(pu.crc(16'hFFFF, EFR_ID_ACK), st));
		chk("cmd", cmd_id_o, id);
		chk("state", op_state_o, os);
	endtask
	task automatic ev(input logic [15:0] a, b, c);
		logic [15:0] p [3];
		p = '{a, b, c};
		@(posedge clock_i);
		evt_valid_i <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			evt_word_i <= p[i];
			do @(posedge clock_i); while (evt_ready_o !== 1'b1);
		end
		evt_valid_i <= 1'b0;
	endtask
	task automatic chkw(input string nm, input logic [15:0] e);
		pu.rd(w);
		chk(nm, w, e);
	endtask
	task automatic ew(input logic [15:0] a, b, c);
		chkw("w1", EFR_START_MARK);
		chkw("w2", 16'h0ABC);
		pu.rd(w);
		chkw("w4", a);
		chkw("w5", b);
		chkw("w6", c);
	endtask
	initial begin
		repeat (12) @(posedge clock_i);
		rst_n_i <= 1'b1;
		wb(1'b0, EFR_REG_CTRL, 32'h0);
		chk("ctrl", q, 32'h0);
		wb(1'b0, EFR_REG_STATUS, 32'h0);
		chk("rst st", q[5:0], EFR_ST_SAFE);
		wb(1'b1, 8'h40, 32'h5A5A);
		wb(1'b0, 8'h40, 32'h0);
		chk("unmap", q, EFR_UNMAPPED);
		wb(1'b1, EFR_REG_HKCYC, 32'h0ABC);
		wb(1'b1, EFR_REG_CTRL, 32'h1);
		cmd(EFR_ID_STATE, 16'h2, 16'h0, EFR_AK_OK, EFR_ST_PATCH);
		cmd(EFR_ID_STATE, 16'h1, 16'h0, EFR_AK_OK, EFR_ST_SAFE);
		cmd(EFR_ID_STATE, 16'h7, 16'h0, EFR_AK_BADNUM, EFR_ST_SAFE);
		cmd(EFR_ID_STATE, 16'h5, 16'h0, EFR_AK_CRC, EFR_ST_SAFE, 1'b0, 1'b1);
		cmd(EFR_ID_STATE, 16'h5, 16'h0, EFR_AK_OK, EFR_ST_SETUP);
		cmd(EFR_ID_STATE, 16'h2, 16'h0, EFR_AK_INVAL, EFR_ST_SETUP);
		cmd(EFR_ID_PINT, 16'h3, 16'h9, EFR_AK_OK, EFR_ST_SETUP, 1'b1);
		cmd(16'h5555, 16'h3, 16'h0, EFR_AK_UNREC, EFR_ST_SETUP);
		n0 = pu.n_ans;
		pu.send(16'hDDDD);
		pu.send(16'hDDDD);
		pu.send(EFR_ID_STATE);
		pu.send(16'h3333);
		pu.send(16'h1111);
		repeat (60) @(posedge clock_i);
		chk("abort", pu.n_ans - n0, 0);
		cmd(EFR_ID_STATE, 16'hA, 16'h0, EFR_AK_OK, EFR_ST_TAKE);
		cmd(EFR_ID_PFLT, 16'h3, 16'h9, EFR_AK_INVAL, EFR_ST_TAKE, 1'b1);
		cmd(EFR_ID_STATE, 16'h14, 16'h0, EFR_AK_INVAL, EFR_ST_TAKE);
		ev(16'h1111, 16'h2222, 16'h3333);
		ew(16'h1111, 16'h2222, 16'h3333);
		wb(1'b1, EFR_REG_MARK, 32'h0002_0007);
		ew(EFR_MARK_IND, 16'h0002, 16'h0007);
		ev(16'h4444, 16'h5555, 16'h6666);
		cmd(EFR_ID_STATE, 16'h5, 16'h0, EFR_AK_OK, EFR_ST_SETUP);
		ew(16'h4444, 16'h5555, 16'h6666);
		ew(EFR_MARK_IND, 16'h0001, 16'h0000);
		repeat (20) @(posedge clock_i);
		wb(1'b0, EFR_REG_STATUS, 32'h0);
		chk("fill", q[29:16] % 6, 0);
		repeat (q[29:16]) pu.rd(w);
		chk("half", hs_half_full_o, 1'b0);
		cmd(EFR_ID_STATE, 16'h14, 16'h64, EFR_AK_OK, EFR_ST_CAL);
		wb(1'b1, EFR_REG_MARK, 32'h0003_0055);
		ew(EFR_MARK_IND, 16'h0003, 16'h0055);
		chkw("w7", 16'h0064);
		repeat (30) chkw("w8 on", 16'h0000);
		tally_and_finish;
	end
endmodule
